//--- bench/rer_host_model.sv
// Host processor model: APB master that polls and clears event bits
`timescale 1ns/10ps
module rer_host_model (
  input  wire logic        clk,     // Bus clock
  output logic             psel,    // APB select
  output logic             penable, // APB access phase
  output logic             pwrite,  // APB direction
  output logic [9:0]       paddr,   // APB byte address
  output logic [31:0]      pwdata,  // APB write data
  input  wire logic [31:0] prdata,  // APB read data
  input  wire logic        pready,  // APB ready
  input  wire logic        pslverr  // APB error
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Events are found by polling, so a transfer is the host's only tool
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic to);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    to = (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rer_host_model

//--- bench/rer_top_sva.sv
// Concurrent checks on the ports of the raw event register block
`timescale 1ns/10ps
module rer_top_sva #(
  parameter longint TIMEOUT_CYCLES = 20, // Receive timeout in clocks
  parameter int     WORD_BITS      = 10  // Bits in a full rx word
) (
  input wire logic                       CLK,        // Clock
  input wire logic                       RESET_N,    // Reset, active low
  input wire logic                       PSEL,       // APB select
  input wire logic                       PENABLE,    // APB access
  input wire logic                       PWRITE,     // APB direction
  input wire logic [rer_pkg::ADDR_W-1:0] PADDR,      // APB address
  input wire logic [31:0]                PWDATA,     // APB write data
  input wire logic [31:0]                PRDATA,     // APB read data
  input wire logic                       PREADY,     // APB ready
  input wire logic                       PSLVERR,    // APB error
  input wire rer_pkg::rer_events_t       EVENTS,     // Event strobes
  input wire logic                       IRQ_OUT,    // Interrupt level
  input wire logic                       IRQ_OUT_OE, // Interrupt drive enable
  input wire logic                       RX_ERROR    // Receive error flag
);
  // ====
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire acc = PSEL && PENABLE;
  property p_ready; PREADY; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  property p_err_phase; PSLVERR |-> acc; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_raw_read;
    acc && !PWRITE && PADDR == {rer_pkg::IDX_RAW, 2'b00}
      |-> PRDATA[31:8] == 24'h0 && PRDATA[7:6] == 2'h0 && !PRDATA[2] && !PSLVERR;
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("reserved raw bits set");
  property p_clr_read;
    acc && !PWRITE && PADDR == {rer_pkg::IDX_CLEAR, 2'b00} |-> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("clear register readable");
  property p_misalign; acc && PADDR[1:0] != 2'h0 |-> PSLVERR; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  property p_irq_pin; IRQ_OUT |-> IRQ_OUT_OE; endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("pin high while undriven");
  property p_mask_off;
    acc && PWRITE && PADDR == {rer_pkg::IDX_MASK, 2'b00} && PWDATA[7:0] == 8'h0 |=> !IRQ_OUT;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  property p_antenna_rx_error_flag_clr;
    acc && PWRITE && PADDR == {rer_pkg::IDX_ANT_CTRL, 2'b00} && PWDATA[0] |=> !RX_ERROR;
  endproperty
  a_antenna_rx_error_flag_clr: assert property (p_antenna_rx_error_flag_clr) else $error("error flag not cleared");
  property p_to_early; EVENTS.tx_done |=> (!$rose(RX_ERROR)) [*8]; endproperty
  a_to_early: assert property (p_to_early) else $error("timeout too early");
endmodule : rer_top_sva
bind rer_top rer_top_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .WORD_BITS(WORD_BITS)) u_rer_top_sva (
  .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EVENTS(EVENTS), .IRQ_OUT(IRQ_OUT), .IRQ_OUT_OE(IRQ_OUT_OE), .RX_ERROR(RX_ERROR));

//--- bench/testbench.sv
// Self-checking bench for the raw event register block
`timescale 1ns/10ps
module testbench;
  localparam logic [9:0] a_raw = {rer_pkg::IDX_RAW, 2'b00};
  localparam logic [9:0] a_sts = {rer_pkg::IDX_STATUS, 2'b00};
  localparam logic [9:0] a_msk = {rer_pkg::IDX_MASK, 2'b00};
  localparam logic [9:0] a_clr = {rer_pkg::IDX_CLEAR, 2'b00};
  localparam logic [9:0] a_misc = {rer_pkg::IDX_MISC_CTRL, 2'b00};
  localparam logic [9:0] a_ant = {rer_pkg::IDX_ANT_CTRL, 2'b00};
  localparam logic [8:0] pre [5] = '{9'h000, 9'h002, 9'h001, 9'h000, 9'h000};
  localparam logic [8:0] endv [5] = '{9'h004, 9'h004, 9'h004, 9'h006, 9'h004};
  localparam logic [7:0] texp [5] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h01};
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq_out, irq_oe, rx_error;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  rer_pkg::rer_events_t ev;
  int fail_count = 0;
  int comparisons = 0;
  rer_top #(.TIMEOUT_CYCLES(20)) u_rer_top (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EVENTS(ev), .IRQ_OUT(irq_out),
    .IRQ_OUT_OE(irq_oe), .RX_ERROR(rx_error));
  rer_host_model u_rer_host_model (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ====
  // Tasks
  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    logic to;
    u_rer_host_model.xfer(w, a, d, r, e, to);
    if (to) begin
      fail_count++;
      report_and_stop();
    end
  endtask : acc
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    acc(1'b1, a, d, r, e);
  endtask : wr
  task automatic rc(input string n, input logic [9:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    acc(1'b0, a, 32'h0, r, e);
    chk(n, r, x);
    chk({n, " error"}, {31'h0, e}, {31'h0, xe});
  endtask : rc
  // Outputs move on the edge that ends a transfer, so look a moment later
  task automatic pins(input logic [2:0] x);
    #1;
    chk("antenna_rx_error_flag oe irq", {29'h0, rx_error, irq_oe, irq_out}, {29'h0, x});
  endtask : pins
  task automatic pulse(input logic [8:0] v);
    @(posedge clk);
    ev <= rer_pkg::rer_events_t'(v);
    @(posedge clk);
    ev <= '0;
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====
  // Main sequence
  initial begin
    reset_n = 1'b0;
    ev = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rc("raw reset", a_raw, 32'h0, 1'b0);
    rc("mask reset", a_msk, 32'h0, 1'b0);
    pins(3'b000);
    rc("unmapped", 10'h000, 32'h0, 1'b1);
    rc("misaligned", a_raw + 10'h1, 32'h0, 1'b1);
    rc("clear read", a_clr, 32'h0, 1'b1);
    $display("Test reset done");
    pulse(9'h100);
    pulse(9'h0d0);
    wr(a_raw, 32'hff);
    rc("raw rx done", a_raw, 32'h30, 1'b0);
    rc("rx error flag", a_ant, 32'h0, 1'b0);
    repeat (25) @(posedge clk);
    wr(a_clr, 32'h0);
    rc("raw kept", a_raw, 32'h30, 1'b0);
    wr(a_clr, 32'h20);
    rc("raw part clear", a_raw, 32'h10, 1'b0);
    $display("Test full receive done");
    pulse(9'h100);
    pulse(9'h0c8);
    rc("raw short", a_raw, 32'h10, 1'b0);
    repeat (25) @(posedge clk);
    rc("raw timeout", a_raw, 32'h18, 1'b0);
    pins(3'b100);
    wr(a_ant, 32'h1);
    pins(3'b000);
    fork
      wr(a_clr, 32'hff);
      begin
        repeat (2) @(posedge clk);
        ev <= rer_pkg::rer_events_t'(9'h100);
        @(posedge clk);
        ev <= '0;
      end
    join
    rc("set wins", a_raw, 32'h10, 1'b0);
    repeat (25) @(posedge clk);
    rc("no reply", a_raw, 32'h18, 1'b0);
    pins(3'b000);
    pulse(9'h0d0);
    rc("rx unarmed", a_raw, 32'h18, 1'b0);
    wr(a_clr, 32'hff);
    $display("Test antenna timeout done");
    for (int i = 0; i < 5; i++) begin
      pulse(pre[i]);
      pulse(endv[i]);
      rc("tuner raw", a_raw, {24'h0, texp[i]}, 1'b0);
      wr(a_clr, 32'hff);
    end
    $display("Test tuner done");
    pulse(9'h004);
    wr(a_msk, 32'h01);
    rc("status", a_sts, 32'h01, 1'b0);
    pins(3'b010);
    wr(a_misc, 32'h04);
    pins(3'b011);
    wr(a_msk, 32'h00);
    rc("status masked", a_sts, 32'h0, 1'b0);
    pins(3'b010);
    wr(a_misc, 32'h00);
    pins(3'b000);
    wr(a_msk, 32'hff);
    rc("mask rw", a_msk, 32'hff, 1'b0);
    pins(3'b010);
    wr(a_clr, 32'h01);
    pins(3'b000);
    $display("Test interrupt done");
    report_and_stop();
  end
endmodule : testbench

//--- shared/rer_pkg.sv
// Package of constants and types for the raw event status register block
// ==========================================================================
// What this block does
// - A one written to a bit of the clear register clears that raw event bit; a zero leaves it.
// - The raw event register is eight bits, read only, resets to zero, bits 7, 6 and 2 read zero.
// - Bit 5 sets when a receive from a second-type antenna ends with a full 10-bit word.
// - A receive ending with fewer than ten bits leaves bit 5 clear and is reported in bit 3.
// - Bit 4 sets when a transmit to the antenna has completed.
// - Bit 3 sets when the 100 ms receive timeout expires, for no reply or an incomplete reply.
// - A timeout caused by an incomplete reply also sets the antenna receive error flag.
// - Bit 1 sets when the tuner does not respond or answers NO ACK where ACK was expected.
// - Bit 0 sets at the end of a tuner bus transaction that completed normally.
// - A tuner transaction that saw any error never sets the done bit.
// - Each masked status bit is raw AND mask, and all of them are ORed into the interrupt.
// - Polarity select zero makes the interrupt active low and undriven when idle; one, active high.
package rer_pkg;

  // ========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ANT_CTRL   = 8'h5f;
  localparam logic [7:0]  IDX_MISC_CTRL  = 8'hee;
  localparam logic [7:0]  IDX_RAW        = 8'hf9;
  localparam logic [7:0]  IDX_STATUS     = 8'hfb;
  localparam logic [7:0]  IDX_MASK       = 8'hfd;
  localparam logic [7:0]  IDX_CLEAR      = 8'hff;
  localparam int          ADDR_W         = 10;

  // ========================================================================
  // Field positions
  localparam int          BIT_TUNER_DONE = 0;
  localparam int          BIT_TUNER_ERR  = 1;
  localparam int          BIT_RX_TIMEOUT = 3;
  localparam int          BIT_TX_DONE    = 4;
  localparam int          BIT_RX_DONE    = 5;
  localparam int          BIT_IRQ_POL    = 2;
  localparam int          BIT_RX_ERR     = 0;
  localparam logic [7:0]  RAW_IMPL_MASK  = 8'h3b;

  // ========================================================================
  // Reset values
  localparam logic [7:0]  RAW_RESET      = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic        POL_RESET      = 1'b0;
  localparam logic        RX_ERR_RESET   = 1'b0;

  // ========================================================================
  // Timing
  localparam longint      CLK_HZ         = 100_000_000;
  localparam longint      RX_TIMEOUT_MS  = 100;
  localparam longint      RX_TIMEOUT_CYC = (RX_TIMEOUT_MS * CLK_HZ) / 1000;
  localparam int          RX_WORD_BITS   = 10;

  // ========================================================================
  // Event strobes from the antenna and tuner engines
  typedef struct packed {
    logic       tx_done;     // Transmit to antenna finished
    logic       rx_end;      // Receive phase ended
    logic [3:0] rx_bits;     // Bits captured, valid with rx_end
    logic       tuner_end;   // Tuner bus transaction ended
    logic       tuner_nack;  // NO ACK where ACK expected
    logic       tuner_nresp; // Tuner did not respond
  } rer_events_t;

endpackage : rer_pkg

//--- src/rer_top.sv
// Raw event status register with mask, clear and interrupt output, APB slave
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module rer_top #(
  parameter longint TIMEOUT_CYCLES = rer_pkg::RX_TIMEOUT_CYC, // Receive timeout in clocks
  parameter int     WORD_BITS      = rer_pkg::RX_WORD_BITS    // Bits in a full rx word
) (
  input  wire logic                       CLK,        // System clock, 100 MHz
  input  wire logic                       RESET_N,    // Asynchronous reset, active low
  input  wire logic                       PSEL,       // APB select
  input  wire logic                       PENABLE,    // APB access phase
  input  wire logic                       PWRITE,     // APB direction, high for write
  input  wire logic [rer_pkg::ADDR_W-1:0] PADDR,      // APB byte address
  input  wire logic [31:0]                PWDATA,     // APB write data
  output logic      [31:0]                PRDATA,     // APB read data
  output logic                            PREADY,     // APB ready
  output logic                            PSLVERR,    // APB error on unmapped address
  input  wire rer_pkg::rer_events_t       EVENTS,     // Event strobes, same clock domain
  output logic                            IRQ_OUT,    // Interrupt request level
  output logic                            IRQ_OUT_OE, // Interrupt pin drive enable
  output logic                            RX_ERROR    // Antenna receive error flag
);

  // ========================================================================
  // Parameter checks
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 64'h0000_0000_ffff_ffff) begin : g_chk_to
    $error("TIMEOUT_CYCLES out of range");
  end
  if (WORD_BITS < 1 || WORD_BITS > 15) begin : g_chk_wb
    $error("WORD_BITS must fit the 4-bit count");
  end

  localparam logic [31:0] TO_LAST = 32'(TIMEOUT_CYCLES - 1);
  localparam logic [3:0]  FULL_W  = 4'(WORD_BITS);

  // ========================================================================
  // State
  logic [7:0]  raw_q;
  logic [7:0]  raw_d;
  logic [7:0]  mask_q;
  logic        pol_q;
  logic        rx_err_q;
  logic        rx_err_d;
  logic        wait_q;
  logic        wait_d;
  logic        partial_q;
  logic        partial_d;
  logic [31:0] to_cnt_q;
  logic [31:0] to_cnt_d;
  logic        tn_err_q;
  logic        tn_err_d;
  logic [31:0] rdata_q;
  logic        unmapped_q;

  // ========================================================================
  // APB decode
  wire [7:0] reg_idx    = PADDR[rer_pkg::ADDR_W-1:2];
  wire       word_ok    = (PADDR[1:0] == 2'h0);
  wire       hit_raw    = word_ok && (reg_idx == rer_pkg::IDX_RAW);
  wire       hit_stat   = word_ok && (reg_idx == rer_pkg::IDX_STATUS);
  wire       hit_mask   = word_ok && (reg_idx == rer_pkg::IDX_MASK);
  wire       hit_clear  = word_ok && (reg_idx == rer_pkg::IDX_CLEAR);
  wire       hit_misc   = word_ok && (reg_idx == rer_pkg::IDX_MISC_CTRL);
  wire       hit_ant    = word_ok && (reg_idx == rer_pkg::IDX_ANT_CTRL);
  wire       hit_any    = hit_raw | hit_stat | hit_mask | hit_clear | hit_misc | hit_ant;
  wire       setup      = PSEL && !PENABLE;
  wire       access     = PSEL && PENABLE;
  // Writes land only in the access phase; the slave never waits
  wire       wr_en      = access && PWRITE;
  wire       wr_mask    = wr_en && hit_mask;
  wire       wr_clear   = wr_en && hit_clear;
  wire       wr_misc    = wr_en && hit_misc;
  wire       wr_ant     = wr_en && hit_ant;

  // ========================================================================
  // Interrupt path
  wire [7:0] masked     = raw_q & mask_q;
  wire       irq_active = |masked;

  // ========================================================================
  // Antenna receive and timeout
  wire       rx_full    = EVENTS.rx_end && (EVENTS.rx_bits == FULL_W);
  wire       rx_short   = EVENTS.rx_end && (EVENTS.rx_bits != FULL_W);
  wire       to_expire  = wait_q && (to_cnt_q == TO_LAST);

  // Timer arms after each transmit and runs until a full word or expiry;
  // a short reply is remembered so the expiry can flag it as an error
  always_comb begin
    wait_d    = wait_q;
    partial_d = partial_q;
    to_cnt_d  = to_cnt_q;
    if (EVENTS.tx_done) begin
      wait_d    = 1'b1;
      partial_d = 1'b0;
      to_cnt_d  = 32'h0000_0000;
    end else if (wait_q) begin
      if (rx_full) begin
        wait_d = 1'b0;
      end else if (to_expire) begin
        wait_d = 1'b0;
      end else begin
        to_cnt_d = to_cnt_q + 32'h0000_0001;
      end
      if (rx_short) begin
        partial_d = 1'b1;
      end
    end
  end

  wire       short_at_to = partial_q | rx_short;
  wire       set_rx_err  = to_expire && short_at_to;

  // Error flag sits at the antenna control word; cleared by writing one
  always_comb begin
    rx_err_d = rx_err_q;
    if (wr_ant && PWDATA[rer_pkg::BIT_RX_ERR]) begin
      rx_err_d = 1'b0;
    end
    if (set_rx_err) begin
      rx_err_d = 1'b1;
    end
  end

  // ========================================================================
  // Tuner bus: any error inside a transaction suppresses its done bit
  wire       tn_fault    = EVENTS.tuner_nack | EVENTS.tuner_nresp;
  wire       tn_bad      = tn_err_q | tn_fault;

  always_comb begin
    tn_err_d = tn_err_q;
    if (EVENTS.tuner_end) begin
      tn_err_d = 1'b0;
    end else if (tn_fault) begin
      tn_err_d = 1'b1;
    end
  end

  // ========================================================================
  // Raw event bits
  logic [7:0] set_vec;
  always_comb begin
    set_vec                          = 8'h00;
    set_vec[rer_pkg::BIT_RX_DONE]    = wait_q && rx_full;
    set_vec[rer_pkg::BIT_TX_DONE]    = EVENTS.tx_done;
    // A full word landing on the expiry cycle wins, so it is not also a timeout
    set_vec[rer_pkg::BIT_RX_TIMEOUT] = to_expire && !rx_full;
    set_vec[rer_pkg::BIT_TUNER_ERR]  = EVENTS.tuner_end && tn_bad;
    set_vec[rer_pkg::BIT_TUNER_DONE] = EVENTS.tuner_end && !tn_bad;
  end

  // Set is applied after the clear so a coinciding event is never lost
  wire [7:0] clr_vec = wr_clear ? PWDATA[7:0] : 8'h00;
  assign raw_d = ((raw_q & ~clr_vec) | set_vec) & rer_pkg::RAW_IMPL_MASK;

  // ========================================================================
  // Read mux, sampled in the setup phase so read data comes from a flop
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_raw) begin
      rd_byte = raw_q;
    end else if (hit_stat) begin
      rd_byte = masked;
    end else if (hit_mask) begin
      rd_byte = mask_q;
    end else if (hit_misc) begin
      rd_byte[rer_pkg::BIT_IRQ_POL] = pol_q;
    end else if (hit_ant) begin
      rd_byte[rer_pkg::BIT_RX_ERR] = rx_err_q;
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      raw_q <= rer_pkg::RAW_RESET;
    end else begin
      raw_q <= raw_d;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_q <= rer_pkg::MASK_RESET;
      pol_q  <= rer_pkg::POL_RESET;
    end else begin
      if (wr_mask) begin
        mask_q <= PWDATA[7:0];
      end
      if (wr_misc) begin
        pol_q <= PWDATA[rer_pkg::BIT_IRQ_POL];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_q    <= 1'b0;
      partial_q <= 1'b0;
      to_cnt_q  <= 32'h0000_0000;
      rx_err_q  <= rer_pkg::RX_ERR_RESET;
      tn_err_q  <= 1'b0;
    end else begin
      wait_q    <= wait_d;
      partial_q <= partial_d;
      to_cnt_q  <= to_cnt_d;
      rx_err_q  <= rx_err_d;
      tn_err_q  <= tn_err_d;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q    <= 32'h0000_0000;
      unmapped_q <= 1'b0;
    end else if (setup) begin
      rdata_q    <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      unmapped_q <= !hit_any || (!PWRITE && hit_clear);
    end
  end

  // ========================================================================
  // Outputs
  assign PRDATA     = rdata_q;
  assign PREADY     = 1'b1;
  assign PSLVERR    = access && unmapped_q;
  // Active low mode only pulls down so several chips can share one line
  assign IRQ_OUT    = pol_q ? irq_active : 1'b0;
  assign IRQ_OUT_OE = pol_q ? 1'b1 : irq_active;
  assign RX_ERROR   = rx_err_q;

endmodule : rer_top
